//--- hdl/sec_params.svh
`ifndef SEC_PARAMS_SVH
`define SEC_PARAMS_SVH

// ----------------------------------------
// Instruction codes, bit 3 is don't-care
// ----------------------------------------
`define SEC_OP_MASK 8'hF7
`define SEC_OP_SET_WEL 8'h06
`define SEC_OP_CLR_WEL 8'h04
`define SEC_OP_SR_RD 8'h05
`define SEC_OP_SR_WR 8'h01
`define SEC_OP_ARR_RD 8'h03
`define SEC_OP_ARR_WR 8'h02

// ----------------------------------------
// Status register layout
// ----------------------------------------
`define SEC_SR_BUSY 0
`define SEC_SR_WEL 1
`define SEC_SR_BP_LO 2
`define SEC_SR_BP_HI 3
`define SEC_SR_HPE 7
`define SEC_SR_BUSY_VAL 8'hFF

// ----------------------------------------
// Block protect codes
// ----------------------------------------
`define SEC_BP_NONE 2'h0
`define SEC_BP_QUARTER 2'h1
`define SEC_BP_HALF 2'h2
`define SEC_BP_ALL 2'h3

// ----------------------------------------
// Array geometry and pins
// ----------------------------------------
`define SEC_ADDR_W 15
`define SEC_PAGE_W 6
`define SEC_PAGE_BYTES 64
`define SEC_PIN_RST 4'h9

// ----------------------------------------
// Timing
// ----------------------------------------
`define SEC_WC_TIME_NS 5000000
`define SEC_CLK_MHZ 250
`define SEC_WC_CYCLES ((`SEC_WC_TIME_NS * `SEC_CLK_MHZ) / 1000)

`endif

//--- hdl/sec_pkg.sv
package sec_pkg;

    typedef enum logic [2:0] {
        CMD_SET_WEL,
        CMD_CLR_WEL,
        CMD_SR_RD,
        CMD_SR_WR,
        CMD_ARR_RD,
        CMD_ARR_WR,
        CMD_BAD
    } sec_cmd_t;

    typedef enum logic [3:0] {
        PH_IDLE,
        PH_OPCODE,
        PH_ADDR_HI,
        PH_ADDR_LO,
        PH_RD_DATA,
        PH_WR_DATA,
        PH_SR_OUT,
        PH_SR_DATA,
        PH_SR_DONE,
        PH_IGNORE
    } sec_phase_t;

    typedef enum logic [1:0] {
        PG_IDLE,
        PG_COPY,
        PG_WAIT
    } sec_prog_t;

endpackage : sec_pkg

//--- hdl/sec_sync.sv
`timescale 1ns/1ps

module sec_sync #(
    parameter int unsigned W = 4,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sec_sync_t;

    sec_sync_t s_r;
    sec_sync_t s_nxt;

    always_comb begin
        s_nxt.s1 = async_in;
        s_nxt.s2 = s_r.s1;
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_r <= {RST_VAL, RST_VAL};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sync_out = s_r.s2;

endmodule : sec_sync

//--- hdl/sec_mem.sv
`timescale 1ns/1ps

module sec_mem #(
    parameter int unsigned AW = 6,
    parameter int unsigned DW = 8
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [DW-1:0] wr_data_in,
    input wire logic rd_en_in,
    input wire logic [AW-1:0] rd_addr_in,
    output logic [DW-1:0] rd_data_out
);

    // Storage is not reset; only the read register is
    logic [DW-1:0] mem_r [0:(1<<AW)-1];
    logic [DW-1:0] rd_r;

    always_ff @(posedge clk_sys_in) begin
        if (wr_en_in) begin
            mem_r[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rd_r <= '0;
        end else if (rd_en_in) begin
            rd_r <= mem_r[rd_addr_in];
        end
    end

    assign rd_data_out = rd_r;

endmodule : sec_mem

//--- hdl/sec_core.sv
`timescale 1ns/1ps
`include "sec_params.svh"

// How it works
// - Bytes shift in MSB first; a command starts only after chip select falls.
// - Set-latch opcode 0000X110 sets the write-enable latch.
// - Clear-latch opcode 0000X100 clears the latch, whatever the protect pin.
// - Status read shifts busy, latch, block-protect and protect-enable out.
// - Status bits 4-6 read zero when idle; all bits read one while busy.
// - Status write sets block-protect and protect-enable bits.
// - Opcode 0000X011 is array read, 0000X010 is array write.
// - Reset clears the write-enable latch.
// - Protect codes: none, top quarter, top half, whole array.
// - Protect bits change only after enable and a timed, busy write cycle.
// - Pin low with protect-enable set refuses all status writes.
// - Protect-enable stays set while the pin holds hardware protection.
// - Protected blocks never written; others need the latch set.
// - Read: opcode, address, then SI ignored and data shifted out MSB first.
// - Read address increments each byte and wraps to zero.
// - While busy, every command except status read is ignored.
// - Write carries opcode, 16-bit address with unused top bits ignored, data.
// - Programming starts only when chip select rises on a byte boundary.
// - Page write increments low six address bits only; wraps in the page.
// - Completed write cycle clears the write-enable latch.
// - Write without latch is discarded until the next chip-select fall.
// - Unknown opcode: input ignored, output off until next select fall.
// - Protect pin falling before select rises abandons a status write when protect-enable is set.
module sec_core #(
    parameter int unsigned ADDR_W = `SEC_ADDR_W,
    parameter int unsigned WRITE_CYCLES = `SEC_WC_CYCLES
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic cs_n_in,
    input wire logic sck_in,
    input wire logic si_in,
    input wire logic wp_n_in,
    output logic so_out,
    output logic so_oe_out,
    output logic busy_out
);

    localparam int unsigned PAGE_W = `SEC_PAGE_W;
    localparam int unsigned PAGE_N = `SEC_PAGE_BYTES;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        sec_pkg::sec_phase_t phase;
        sec_pkg::sec_prog_t prog;
        sec_pkg::sec_cmd_t cmd;
        logic cs_prev;
        logic sck_prev;
        logic [7:0] shift_in;
        logic [2:0] bit_cnt;
        logic [2:0] out_cnt;
        logic [7:0] tx;
        logic so;
        logic so_oe;
        logic [ADDR_W-1:0] addr;
        logic [ADDR_W-1:0] page_addr;
        logic wel;
        logic [1:0] bp;
        logic hpe;
        logic [PAGE_N-1:0] mask;
        logic sr_pend;
        logic [2:0] sr_new;
        logic [PAGE_W:0] idx;
        logic [31:0] timer;
        logic rd_req;
    } sec_core_state_t;

    // Select line idles high; phase and prog start in their idle states, cmd at CMD_SET_WEL
    localparam sec_core_state_t RST_STATE = '{phase: sec_pkg::PH_IDLE, prog: sec_pkg::PG_IDLE,
        cmd: sec_pkg::CMD_SET_WEL, cs_prev: 1'b1, default: '0};

    sec_core_state_t s_r;
    sec_core_state_t s_nxt;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic sec_pkg::sec_cmd_t decode_op(input logic [7:0] op);
        logic [7:0] m;
        m = op & `SEC_OP_MASK;
        case (m)
            `SEC_OP_SET_WEL: decode_op = sec_pkg::CMD_SET_WEL;
            `SEC_OP_CLR_WEL: decode_op = sec_pkg::CMD_CLR_WEL;
            `SEC_OP_SR_RD: decode_op = sec_pkg::CMD_SR_RD;
            `SEC_OP_SR_WR: decode_op = sec_pkg::CMD_SR_WR;
            `SEC_OP_ARR_RD: decode_op = sec_pkg::CMD_ARR_RD;
            `SEC_OP_ARR_WR: decode_op = sec_pkg::CMD_ARR_WR;
            default: decode_op = sec_pkg::CMD_BAD;
        endcase
    endfunction : decode_op

    function automatic logic is_protected(input logic [1:0] bp,
                                          input logic [ADDR_W-1:0] a);
        case (bp)
            `SEC_BP_NONE: is_protected = 1'b0;
            `SEC_BP_QUARTER: is_protected = &a[ADDR_W-1 -: 2];
            `SEC_BP_HALF: is_protected = a[ADDR_W-1];
            default: is_protected = 1'b1;
        endcase
    endfunction : is_protected

    function automatic logic [7:0] status_byte(input logic busy,
                                               input logic wel,
                                               input logic [1:0] bp,
                                               input logic hpe);
        logic [7:0] b;
        b = 8'h00;
        b[`SEC_SR_WEL] = wel;
        b[`SEC_SR_BP_LO] = bp[0];
        b[`SEC_SR_BP_HI] = bp[1];
        b[`SEC_SR_HPE] = hpe;
        status_byte = busy ? `SEC_SR_BUSY_VAL : b;
    endfunction : status_byte

    // ----------------------------------------
    // Pin synchronisers and memories
    // ----------------------------------------
    logic [3:0] pins_s;
    logic cs_s;
    logic sck_s;
    logic si_s;
    logic wp_s;
    logic [7:0] arr_rd;
    logic [7:0] buf_rd;
    logic buf_we;
    logic buf_re;
    logic arr_we;
    logic [ADDR_W-1:0] arr_wa;
    logic [7:0] byte_in;

    sec_sync #(
        .W(4),
        .RST_VAL(`SEC_PIN_RST)
    ) u_sync (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .async_in({cs_n_in, sck_in, si_in, wp_n_in}),
        .sync_out(pins_s)
    );

    assign {cs_s, sck_s, si_s, wp_s} = pins_s;

    sec_mem #(
        .AW(ADDR_W),
        .DW(8)
    ) u_array (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .wr_en_in(arr_we),
        .wr_addr_in(arr_wa),
        .wr_data_in(buf_rd),
        .rd_en_in(s_r.rd_req),
        .rd_addr_in(s_r.addr),
        .rd_data_out(arr_rd)
    );

    // Page buffer: bytes land here and reach the array only on a clean finish
    sec_mem #(
        .AW(PAGE_W),
        .DW(8)
    ) u_page (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .wr_en_in(buf_we),
        .wr_addr_in(s_r.addr[PAGE_W-1:0]),
        .wr_data_in(byte_in),
        .rd_en_in(buf_re),
        .rd_addr_in(s_r.idx[PAGE_W-1:0]),
        .rd_data_out(buf_rd)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic busy;
        logic hw_prot;
        logic cs_fall;
        logic cs_rise;
        logic sck_rise;
        logic sck_fall;
        logic in_phase;
        logic [7:0] ob;
        logic [PAGE_W:0] idx_m1;
        logic [ADDR_W-1:0] full_addr;
        sec_pkg::sec_cmd_t c;
        s_nxt = s_r;
        busy = (s_r.prog != sec_pkg::PG_IDLE);
        hw_prot = ~wp_s & s_r.hpe;
        cs_fall = s_r.cs_prev & ~cs_s;
        cs_rise = ~s_r.cs_prev & cs_s;
        sck_rise = ~s_r.sck_prev & sck_s & ~cs_s;
        sck_fall = s_r.sck_prev & ~sck_s & ~cs_s;
        byte_in = {s_r.shift_in[6:0], si_s};
        idx_m1 = s_r.idx - 1'b1;
        full_addr = {s_r.addr[ADDR_W-1:8], byte_in};
        c = decode_op(byte_in);
        ob = 8'h00;
        buf_we = 1'b0;
        buf_re = 1'b0;
        arr_we = 1'b0;
        arr_wa = {s_r.page_addr[ADDR_W-1:PAGE_W], idx_m1[PAGE_W-1:0]};
        s_nxt.rd_req = 1'b0;
        s_nxt.cs_prev = cs_s;
        s_nxt.sck_prev = sck_s;
        in_phase = (s_r.phase == sec_pkg::PH_OPCODE) || (s_r.phase == sec_pkg::PH_ADDR_HI)
            || (s_r.phase == sec_pkg::PH_ADDR_LO) || (s_r.phase == sec_pkg::PH_WR_DATA)
            || (s_r.phase == sec_pkg::PH_SR_DATA) || (s_r.phase == sec_pkg::PH_SR_DONE);

        // ----------------------------------------
        // Self-timed programming
        // ----------------------------------------
        case (s_r.prog)
            sec_pkg::PG_IDLE: begin
            end
            sec_pkg::PG_COPY: begin
                s_nxt.timer = s_r.timer - 32'h1;
                buf_re = (s_r.idx != PAGE_W'(0) + 7'h40);
                arr_we = (s_r.idx != 7'h00) && s_r.mask[idx_m1[PAGE_W-1:0]];
                if (s_r.idx == 7'h40) begin
                    s_nxt.prog = sec_pkg::PG_WAIT;
                end else begin
                    s_nxt.idx = s_r.idx + 7'h01;
                end
            end
            sec_pkg::PG_WAIT: begin
                s_nxt.timer = s_r.timer - 32'h1;
                if (s_r.timer <= 32'h1) begin
                    s_nxt.prog = sec_pkg::PG_IDLE;
                    s_nxt.wel = 1'b0;
                    if (s_r.sr_pend) begin
                        s_nxt.hpe = s_r.sr_new[2];
                        s_nxt.bp = s_r.sr_new[1:0];
                        s_nxt.sr_pend = 1'b0;
                    end
                end
            end
            default: s_nxt.prog = sec_pkg::PG_IDLE;
        endcase

        // ----------------------------------------
        // Serial link
        // ----------------------------------------
        if (cs_rise) begin
            s_nxt.phase = sec_pkg::PH_IDLE;
            s_nxt.so_oe = 1'b0;
            // Partial bytes never start a cycle
            if (s_r.phase == sec_pkg::PH_WR_DATA && s_r.bit_cnt == 3'h0
                && s_r.mask != '0) begin
                s_nxt.prog = sec_pkg::PG_COPY;
                s_nxt.idx = '0;
                s_nxt.timer = WRITE_CYCLES;
            end else if (s_r.phase == sec_pkg::PH_SR_DONE && s_r.bit_cnt == 3'h0
                && !hw_prot) begin
                s_nxt.prog = sec_pkg::PG_WAIT;
                s_nxt.sr_pend = 1'b1;
                s_nxt.timer = WRITE_CYCLES;
            end
        end else if (cs_fall) begin
            s_nxt.phase = sec_pkg::PH_OPCODE;
            s_nxt.bit_cnt = 3'h0;
            s_nxt.out_cnt = 3'h0;
            s_nxt.so_oe = 1'b0;
        end else if (sck_rise && in_phase) begin
            s_nxt.shift_in = byte_in;
            s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
            if (s_r.bit_cnt == 3'h7) begin
                case (s_r.phase)
                    sec_pkg::PH_OPCODE: begin
                        s_nxt.cmd = c;
                        s_nxt.phase = sec_pkg::PH_IGNORE;
                        if (busy && c != sec_pkg::CMD_SR_RD) begin
                            s_nxt.phase = sec_pkg::PH_IGNORE;
                        end else begin
                            case (c)
                                sec_pkg::CMD_SET_WEL: s_nxt.wel = 1'b1;
                                sec_pkg::CMD_CLR_WEL: s_nxt.wel = 1'b0;
                                sec_pkg::CMD_SR_RD: s_nxt.phase = sec_pkg::PH_SR_OUT;
                                sec_pkg::CMD_SR_WR: begin
                                    if (s_r.wel && !hw_prot) begin
                                        s_nxt.phase = sec_pkg::PH_SR_DATA;
                                    end
                                end
                                sec_pkg::CMD_ARR_RD: s_nxt.phase = sec_pkg::PH_ADDR_HI;
                                sec_pkg::CMD_ARR_WR: begin
                                    s_nxt.mask = '0;
                                    if (s_r.wel) begin
                                        s_nxt.phase = sec_pkg::PH_ADDR_HI;
                                    end
                                end
                                default: s_nxt.phase = sec_pkg::PH_IGNORE;
                            endcase
                        end
                    end
                    sec_pkg::PH_ADDR_HI: begin
                        // Address bits above the array are dropped
                        s_nxt.addr[ADDR_W-1:8] = byte_in[ADDR_W-9:0];
                        s_nxt.phase = sec_pkg::PH_ADDR_LO;
                    end
                    sec_pkg::PH_ADDR_LO: begin
                        s_nxt.addr = full_addr;
                        s_nxt.page_addr = full_addr;
                        if (s_r.cmd == sec_pkg::CMD_ARR_RD) begin
                            s_nxt.phase = sec_pkg::PH_RD_DATA;
                            s_nxt.rd_req = 1'b1;
                        end else if (is_protected(s_r.bp, full_addr)) begin
                            s_nxt.phase = sec_pkg::PH_IGNORE;
                        end else begin
                            s_nxt.phase = sec_pkg::PH_WR_DATA;
                        end
                    end
                    sec_pkg::PH_WR_DATA: begin
                        buf_we = 1'b1;
                        s_nxt.mask[s_r.addr[PAGE_W-1:0]] = 1'b1;
                        s_nxt.addr[PAGE_W-1:0] = s_r.addr[PAGE_W-1:0] + 6'h01;
                    end
                    sec_pkg::PH_SR_DATA: begin
                        s_nxt.sr_new = {byte_in[`SEC_SR_HPE], byte_in[`SEC_SR_BP_HI],
                                        byte_in[`SEC_SR_BP_LO]};
                        s_nxt.phase = sec_pkg::PH_SR_DONE;
                    end
                    default: s_nxt.phase = sec_pkg::PH_IGNORE;
                endcase
            end
        end else if (sck_fall && (s_r.phase == sec_pkg::PH_RD_DATA
                                  || s_r.phase == sec_pkg::PH_SR_OUT)) begin
            s_nxt.out_cnt = s_r.out_cnt + 3'h1;
            s_nxt.so_oe = 1'b1;
            if (s_r.out_cnt == 3'h0) begin
                if (s_r.phase == sec_pkg::PH_SR_OUT) begin
                    ob = status_byte(busy, s_r.wel, s_r.bp, s_r.hpe);
                end else begin
                    ob = arr_rd;
                    s_nxt.addr = s_r.addr + 1'b1;
                    s_nxt.rd_req = 1'b1;
                end
                s_nxt.so = ob[7];
                s_nxt.tx = {ob[6:0], 1'b0};
            end else begin
                s_nxt.so = s_r.tx[7];
                s_nxt.tx = {s_r.tx[6:0], 1'b0};
            end
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_r <= RST_STATE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign so_out = s_r.so;
    assign so_oe_out = s_r.so_oe;
    assign busy_out = (s_r.prog != sec_pkg::PG_IDLE);

endmodule : sec_core

//--- testbench/sec_host_model.sv
`timescale 1ns/1ps

module sec_host_model (
    output logic cs_n_out,
    output logic sck_out,
    output logic si_out,
    input wire logic so_in,
    input wire logic so_oe_in
);
    logic so_last;
    logic so_line;

    // Released line drifts: show the inverse of its last driven level
    always @(so_in or so_oe_in) begin
        if (so_oe_in) begin
            so_last = so_in;
        end
    end
    assign so_line = so_oe_in ? so_in : ~so_last;

    initial begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        si_out = 1'b0;
        so_last = 1'b0;
    end

    // Pin edges may land on a system clock edge; non-blocking updates avoid the race
    task automatic sel();
        cs_n_out <= 1'b0;
        #100;
    endtask : sel

    task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si_out <= tx[i];
            #62.5 sck_out <= 1'b1;
            rx[i] = so_line;
            #62.5 sck_out <= 1'b0;
        end
    endtask : xb

    task automatic desel();
        #30 cs_n_out <= 1'b1;
        si_out <= ~si_out;
        #150;
    endtask : desel
endmodule : sec_host_model

//--- testbench/sec_core_assertions.sv
`timescale 1ns/1ps

module sec_core_assertions #(
    parameter int unsigned ADDR_W = 15,
    parameter int unsigned WRITE_CYCLES = 1250000
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic cs_n_in,
    input wire logic sck_in,
    input wire logic si_in,
    input wire logic wp_n_in,
    input wire logic so_out,
    input wire logic so_oe_out,
    input wire logic busy_out
);
    logic [31:0] busy_cnt_r;
    logic [31:0] busy_cnt_nxt;

    always_comb busy_cnt_nxt = busy_out ? busy_cnt_r + 32'h1 : 32'h0;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            busy_cnt_r <= 32'h0;
        end else begin
            busy_cnt_r <= busy_cnt_nxt;
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);

    sequence s_cs_rise;
        $rose(cs_n_in);
    endsequence
    sequence s_quiet;
        !so_oe_out [*4];
    endsequence
    sequence s_busy_hold;
        busy_out [*8];
    endsequence

    AST_IDLE_OFF: assert property (cs_n_in [*8] |-> !so_oe_out)
        else $error("output driven while deselected");
    AST_OE_DROP: assert property (s_cs_rise |-> ##[1:6] s_quiet)
        else $error("output not released after select rise");
    AST_OE_RISE: assert property ($rose(so_oe_out) |-> !sck_in && !cs_n_in)
        else $error("output enabled outside clock low phase");
    AST_SO_AFTER_FALL: assert property (
        ($changed(so_out) && so_oe_out && $past(so_oe_out)) |-> !sck_in)
        else $error("output changed while clock high");
    AST_SO_STABLE_HIGH: assert property (
        (so_oe_out && sck_in && $past(sck_in, 4)) |-> $stable(so_out))
        else $error("output moved in clock high phase");
    AST_BUSY_START: assert property ($rose(busy_out) |-> cs_n_in && $past(cs_n_in, 2))
        else $error("busy began with select low");
    AST_BUSY_HOLD: assert property ($rose(busy_out) |=> s_busy_hold)
        else $error("busy dropped too early");
    AST_BUSY_LEN: assert property ($fell(busy_out) |->
        busy_cnt_r >= WRITE_CYCLES - 2 && busy_cnt_r <= WRITE_CYCLES + 2)
        else $error("busy window length wrong");
    AST_BUSY_MAX: assert property (busy_cnt_r <= WRITE_CYCLES + 2)
        else $error("busy window too long");
    AST_RESET_QUIET: assert property ($rose(resetn_in) |-> !busy_out && !so_oe_out)
        else $error("outputs active after reset");
endmodule : sec_core_assertions

bind sec_core sec_core_assertions #(
    .ADDR_W(ADDR_W),
    .WRITE_CYCLES(WRITE_CYCLES)
) u_chk (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .cs_n_in(cs_n_in),
    .sck_in(sck_in),
    .si_in(si_in),
    .wp_n_in(wp_n_in),
    .so_out(so_out),
    .so_oe_out(so_oe_out),
    .busy_out(busy_out)
);

//--- testbench/sec_core_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", nm, e, a); end end

module sec_core_bench;
    localparam int unsigned WC = 2000;
    logic clk_sys;
    logic resetn;
    logic wp_n;
    logic cs_n_w, sck_w, si_w, so_w, oe_w, busy_w;
    int error_cnt;
    int checks;
    logic [7:0] s;
    logic [7:0] got [4];
    logic [7:0] row_op [6] = '{8'h06, 8'h04, 8'h0E, 8'h0C, 8'h06, 8'h55};
    logic [7:0] row_sr [6] = '{8'h02, 8'h00, 8'h02, 8'h00, 8'h02, 8'h02};
    logic [7:0] bp_sr [3] = '{8'h04, 8'h08, 8'h0C};
    logic [15:0] bp_a [3] = '{16'h6000, 16'h4000, 16'h0000};

    sec_core #(.ADDR_W(15), .WRITE_CYCLES(WC)) DUT (
        .clk_sys_in(clk_sys), .resetn_in(resetn), .cs_n_in(cs_n_w), .sck_in(sck_w),
        .si_in(si_w), .wp_n_in(wp_n), .so_out(so_w), .so_oe_out(oe_w), .busy_out(busy_w));
    sec_host_model host (.cs_n_out(cs_n_w), .sck_out(sck_w), .si_out(si_w),
        .so_in(so_w), .so_oe_in(oe_w));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // Frame helpers
    // ----------------------------------------
    task automatic cmd1(input logic [7:0] op);
        logic [7:0] r;
        host.sel();
        host.xb(op, r);
        host.desel();
    endtask : cmd1

    task automatic frame(input logic [7:0] q [$]);
        logic [7:0] r;
        host.sel();
        foreach (q[i]) host.xb(q[i], r);
        host.desel();
    endtask : frame

    task automatic sr_rd();
        logic [7:0] r;
        host.sel();
        host.xb(8'h05, r);
        host.xb(8'h00, s);
        host.desel();
    endtask : sr_rd

    task automatic rd(input logic [15:0] a, input int n);
        logic [7:0] r;
        host.sel();
        host.xb(8'h03, r);
        host.xb(a[15:8], r);
        host.xb(a[7:0], r);
        // Input after the address must be ignored
        for (int i = 0; i < n; i++) host.xb(8'hA5, got[i]);
        host.desel();
    endtask : rd

    task automatic chk_busy(input logic e);
        @(negedge clk_sys);
        `CHK("busy", e, busy_w)
    endtask : chk_busy

    task automatic wait_idle();
        for (int i = 0; i < 3 * WC; i++) begin
            @(negedge clk_sys);
            if (busy_w === 1'b0) break;
        end
        `CHK("busy_end", 1'b0, busy_w)
    endtask : wait_idle

    task automatic set_sr(input logic [7:0] v);
        cmd1(8'h06);
        frame({8'h01, v});
        wait_idle();
    endtask : set_sr

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    // ----------------------------------------
    // Watchdog, about 100k clock cycles
    // ----------------------------------------
    initial begin
        #400000;
        error_cnt++;
        print_verdict();
    end

    initial begin
        error_cnt = 0;
        checks = 0;
        resetn = 1'b0;
        wp_n = 1'b1;
        repeat (8) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (4) @(negedge clk_sys);
        `CHK("oe_idle", 1'b0, oe_w)
        chk_busy(1'b0);
        sr_rd();
        `CHK("sr_reset", 8'h00, s)
        foreach (row_op[i]) begin
            cmd1(row_op[i]);
            sr_rd();
            `CHK("sr_row", row_sr[i], s)
        end
        cmd1(8'h04);
        // Page write running past the page end
        cmd1(8'h06);
        frame({8'h02, 8'h00, 8'h3E, 8'hA1, 8'hA2, 8'hA3});
        chk_busy(1'b1);
        cmd1(8'h06);
        sr_rd();
        `CHK("sr_busy", 8'hFF, s)
        wait_idle();
        sr_rd();
        `CHK("sr_after", 8'h00, s)
        rd(16'h803E, 2);
        `CHK("rd0", 8'hA1, got[0])
        `CHK("rd1", 8'hA2, got[1])
        // Write without the latch is dropped
        frame({8'h02, 8'h01, 8'h00, 8'h5A});
        chk_busy(1'b0);
        foreach (bp_sr[i]) begin
            set_sr(bp_sr[i]);
            cmd1(8'h06);
            frame({8'h02, bp_a[i][15:8], bp_a[i][7:0], 8'h99});
            chk_busy(1'b0);
        end
        rd(16'h0000, 1);
        `CHK("page_wrap", 8'hA3, got[0])
        set_sr(8'h84);
        sr_rd();
        `CHK("sr_84", 8'h84, s)
        cmd1(8'h06);
        frame({8'h02, 8'h5F, 8'hFF, 8'h22});
        chk_busy(1'b1);
        wait_idle();
        rd(16'h5FFF, 1);
        `CHK("rd_5fff", 8'h22, got[0])
        @(negedge clk_sys);
        wp_n = 1'b0;
        cmd1(8'h06);
        frame({8'h01, 8'h00});
        chk_busy(1'b0);
        sr_rd();
        `CHK("sr_hw", 8'h86, s)
        @(negedge clk_sys);
        wp_n = 1'b1;
        frame({8'h01, 8'h00});
        chk_busy(1'b1);
        wait_idle();
        sr_rd();
        `CHK("sr_clr", 8'h00, s)
        cmd1(8'h06);
        frame({8'h02, 8'hFF, 8'hFF, 8'h77});
        wait_idle();
        rd(16'h7FFF, 2);
        `CHK("rd_top", 8'h77, got[0])
        `CHK("rd_wrap", 8'hA3, got[1])
        print_verdict();
    end
endmodule : sec_core_bench
